// *** design/wbcr_pkg.sv ***
// constants, offsets and field layout of the boost control register bank
package wbcr_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] WBCR_OFS_OVP_THRESHOLD = 8'h20;
  localparam logic [7:0] WBCR_OFS_FIXED_CFG_A   = 8'h21;
  localparam logic [7:0] WBCR_OFS_FIXED_CFG_B   = 8'h22;
  localparam logic [7:0] WBCR_OFS_ENABLE_STATUS = 8'h23;

  // field positions
  localparam int WBCR_OVP_CODE_LSB = 0;
  localparam int WBCR_OVP_CODE_W   = 6;
  localparam int WBCR_ON_BIT       = 0;
  localparam int WBCR_OK_BIT       = 1;
  localparam int WBCR_B23_WE_LO    = 2;
  localparam int WBCR_B23_RO_BIT   = 3;

  // writable masks of each register (write-exact bits are stored as written)
  localparam logic [7:0] WBCR_MASK_OVP_THRESHOLD = 8'h3f;
  localparam logic [7:0] WBCR_MASK_FIXED_CFG_A   = 8'h01;
  localparam logic [7:0] WBCR_MASK_FIXED_CFG_B   = 8'h3f;
  localparam logic [7:0] WBCR_MASK_ENABLE_STATUS = 8'hf5;

  // reset values of the stored bits
  localparam logic [5:0] WBCR_RST_OVP_CODE  = 6'h3f;
  localparam logic [7:0] WBCR_RST_FIXED_A   = 8'h00;
  localparam logic [7:0] WBCR_RST_FIXED_B   = 8'h00;
  localparam logic [7:0] WBCR_RST_ENABLE_ST = 8'h00;
  localparam logic [15:0] WBCR_RST_OVP_MV   = 16'h6f54; // decoded reset code, 28500 mV

  // value that read-only bits return
  localparam logic [7:0] WBCR_RO_FILL = 8'h00;

  // threshold table steps in millivolts
  localparam int WBCR_BASE_LOW_MV  = 5000;
  localparam int WBCR_STEP_LOW_MV  = 250;
  localparam int WBCR_RANGE_LOW_MV = 2000;
  localparam int WBCR_BASE_HIGH_MV = 13000;
  localparam int WBCR_STEP_HIGH_MV = 500;
  localparam int WBCR_RANGE_HIGH_MV = 4000;

endpackage : wbcr_pkg

// *** design/wbcr_ovp_decode.sv ***
// over-voltage threshold code to millivolt decoder, registered output
`timescale 1ns/1ps
module wbcr_ovp_decode (
  input  wire logic        clk_sys_i,  // system clock
  input  wire logic        srst_i,     // synchronous reset, high
  input  wire logic [5:0]  code_i,     // threshold code
  output logic      [15:0] mv_o        // threshold in millivolts
);
  import wbcr_pkg::*;

  logic [15:0] next_mv;

  // coarse range in upper bits, step in lower bits
  always_comb begin
    if (code_i[5] == 1'b0) begin
      next_mv = 16'(WBCR_BASE_LOW_MV + int'(code_i[4:3]) * WBCR_RANGE_LOW_MV
                + int'(code_i[2:0]) * WBCR_STEP_LOW_MV);
    end else begin
      next_mv = 16'(WBCR_BASE_HIGH_MV + int'(code_i[4:3]) * WBCR_RANGE_HIGH_MV
                + int'(code_i[2:0]) * WBCR_STEP_HIGH_MV);
    end
  end

  // register the decoded value
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mv_o <= WBCR_RST_OVP_MV;
    end else begin
      mv_o <= next_mv;
    end
  end
endmodule : wbcr_ovp_decode

// *** design/wbcr_regs.sv ***
// boost converter control and status register bank
//
// What this block does
// R1 - the converter enable output follows bit 0 of register 0x23, readable and writable.
// R2 - the enable is changed only by register writes on the serial register port, no pin.
// R3 - bit 1 of 0x23 reads 1 while output is OK and 0 while the sense node exceeds threshold.
// R4 - bits 5:0 of 0x20 are the threshold code, upper three coarse range, lower three step.
// R5 - the threshold code resets to 111111, the highest setting, and writes may lower it.
// R6 - read-only bits ignore writes and read as a fixed fill value.
// R7 - the host writes write-exact bits only with their defaults; they stay readable.
// R8 - the power-OK bit shows the live comparator each read, not a latched value.
//
// notes for users of this block
// - a write is taken on the edge where wr_en_i is high; the converter enable and
//   the threshold code follow one cycle later, the decoded millivolts one more.
// - a read is taken on the edge where rd_en_i is high; rvalid_o pulses one cycle
//   later and rdata_o holds until the next read.
// - a write and a read of one offset on one edge return the old stored value.
// - the power-OK bit is not stored: it is the comparator level at the read edge,
//   so a short excursion between two reads is not seen by the host.
// - write-exact bits are kept exactly as written so the host can read them back;
//   nothing in this block acts on them.
// - read-only bits return the fill value whatever was written.
// - unmapped offsets ignore writes and read as zero, with a normal valid pulse.
`timescale 1ns/1ps
module wbcr_regs (
  input  wire logic        clk_sys_i,    // system clock, 250 MHz
  input  wire logic        srst_i,       // synchronous reset, high
  input  wire logic        wr_en_i,      // register write strobe, one cycle
  input  wire logic        rd_en_i,      // register read strobe, one cycle
  input  wire logic [7:0]  addr_i,       // register offset
  input  wire logic [7:0]  wdata_i,      // write data
  input  wire logic        ov_above_i,   // comparator: sense node above threshold
  output logic      [7:0]  rdata_o,      // read data, valid with rvalid_o
  output logic             rvalid_o,     // read data valid pulse
  output logic             boost_on_o,   // converter enable
  output logic      [5:0]  ovp_threshold_code_o, // threshold code to analog
  output logic      [15:0] ovp_mv_o      // decoded threshold in millivolts
);
  import wbcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks on the package layout

  // code field must be bits 5:0 to match the code port
  if (WBCR_OVP_CODE_W != 6 || WBCR_OVP_CODE_LSB != 0) begin : g_chk_code_field
    $error("threshold code field must sit in bits 5 to 0");
  end

  // threshold register stores only the code field
  if (WBCR_MASK_OVP_THRESHOLD != 8'h3f) begin : g_chk_ovp_mask
    $error("threshold register mask must cover the code field only");
  end

  // enable bit must be writable, status and read-only bits must not be
  if (!WBCR_MASK_ENABLE_STATUS[WBCR_ON_BIT]
      || WBCR_MASK_ENABLE_STATUS[WBCR_OK_BIT]
      || WBCR_MASK_ENABLE_STATUS[WBCR_B23_RO_BIT]) begin : g_chk_en_mask
    $error("enable register mask does not fit its bit layout");
  end

  // enable, status and read-only bits must be distinct positions
  if (WBCR_ON_BIT == WBCR_OK_BIT || WBCR_OK_BIT == WBCR_B23_RO_BIT
      || WBCR_ON_BIT == WBCR_B23_RO_BIT) begin : g_chk_bit_pos
    $error("enable register bit positions overlap");
  end

  // write-exact bit 2 must be stored
  if (!WBCR_MASK_ENABLE_STATUS[WBCR_B23_WE_LO]) begin : g_chk_we_bit
    $error("write-exact bit of the enable register must be stored");
  end

  ////////////////////////////////////////////////////////////////////////
  // stored fields

  logic [5:0] ovp_code;
  logic [7:0] fixed_a;
  logic [7:0] fixed_b;
  logic [7:0] en_st;
  logic [7:0] next_rdata;
  logic       wr_ovp;  // write hit, threshold register
  logic       wr_enst; // write hit, enable/status register

  // write address decode, shared by store and output flops
  always_comb begin
    wr_ovp  = wr_en_i && (addr_i == WBCR_OFS_OVP_THRESHOLD);
    wr_enst = wr_en_i && (addr_i == WBCR_OFS_ENABLE_STATUS);
  end

  // threshold code register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ovp_code <= WBCR_RST_OVP_CODE; // R5
    end else if (wr_ovp) begin
      ovp_code <= wdata_i[5:0] & WBCR_MASK_OVP_THRESHOLD[5:0]; // R4 R6
    end
  end

  // write-exact holding registers, stored as written
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fixed_a <= WBCR_RST_FIXED_A;
      fixed_b <= WBCR_RST_FIXED_B;
    end else if (wr_en_i) begin
      if (addr_i == WBCR_OFS_FIXED_CFG_A) begin
        fixed_a <= wdata_i & WBCR_MASK_FIXED_CFG_A; // R6 R7
      end
      if (addr_i == WBCR_OFS_FIXED_CFG_B) begin
        fixed_b <= wdata_i & WBCR_MASK_FIXED_CFG_B; // R6 R7
      end
    end
  end

  // enable and write-exact bits of the enable/status register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      en_st <= WBCR_RST_ENABLE_ST;
    end else if (wr_enst) begin
      en_st <= wdata_i & WBCR_MASK_ENABLE_STATUS; // R1 R2 R6 R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to the converter

  // enable and code driven from flops
  // the write data is forwarded so the pins move one cycle after the write
  // edge, not two; otherwise they mirror the stored fields
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      boost_on_o           <= 1'b0;
      ovp_threshold_code_o <= WBCR_RST_OVP_CODE;
    end else begin
      boost_on_o           <= wr_enst
                              ? wdata_i[WBCR_ON_BIT] : en_st[WBCR_ON_BIT]; // R1 R2
      ovp_threshold_code_o <= wr_ovp
                              ? wdata_i[5:0] : ovp_code; // R4
    end
  end

  // threshold decoder
  wbcr_ovp_decode u_decode (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .code_i    (ovp_code),
    .mv_o      (ovp_mv_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path

  // read mux, status sampled live
  // the ok bit is taken from the comparator at the read edge, never stored
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr_i)
      WBCR_OFS_OVP_THRESHOLD: begin
        next_rdata = (WBCR_RO_FILL & ~WBCR_MASK_OVP_THRESHOLD) | {2'b00, ovp_code}; // R6
      end
      WBCR_OFS_FIXED_CFG_A: begin
        next_rdata = (WBCR_RO_FILL & ~WBCR_MASK_FIXED_CFG_A) | fixed_a; // R6 R7
      end
      WBCR_OFS_FIXED_CFG_B: begin
        next_rdata = (WBCR_RO_FILL & ~WBCR_MASK_FIXED_CFG_B) | fixed_b; // R6 R7
      end
      WBCR_OFS_ENABLE_STATUS: begin
        next_rdata = en_st;
        next_rdata[WBCR_OK_BIT] = ~ov_above_i; // R3 R8
        next_rdata[WBCR_B23_RO_BIT] = WBCR_RO_FILL[WBCR_B23_RO_BIT]; // R6
      end
      default: begin
        next_rdata = 8'h00; // unmapped reads zero
      end
    endcase
  end

  // read data register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= next_rdata; // R3 R8
      end
    end
  end

endmodule : wbcr_regs

// *** verif/wbcr_regs_props.sv ***
// port assertions, boost register bank
`timescale 1ns/1ps
module wbcr_regs_props (
  input wire logic        clk_sys_i, srst_i,        // clock, reset
  input wire logic        wr_en_i, rd_en_i,         // strobes
  input wire logic        ov_above_i, rvalid_o,     // comparator, valid
  input wire logic        boost_on_o,               // enable
  input wire logic [7:0]  addr_i, wdata_i, rdata_o, // bus
  input wire logic [5:0]  ovp_threshold_code_o,     // code
  input wire logic [15:0] ovp_mv_o                  // millivolts
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // read-only mask of the addressed register
  wire [7:0] ro_m = (addr_i == 8'h21) ? 8'hfe : (addr_i == 8'h23) ? 8'h08 : 8'hc0;
  // threshold in millivolts
  function automatic logic [15:0] mv(input logic [5:0] c);
    mv = c[5] ? 16'(13000 + c[4:3] * 4000 + c[2:0] * 500)
              : 16'(5000 + c[4:3] * 2000 + c[2:0] * 250);
  endfunction : mv
  a_on_write: assert property (wr_en_i && addr_i == 8'h23 |=>
    boost_on_o == $past(wdata_i[0])) else $error("enable");
  a_on_held: assert property (!(wr_en_i && addr_i == 8'h23) |=>
    $stable(boost_on_o)) else $error("enable moved");
  a_ok_live: assert property (rd_en_i && addr_i == 8'h23 |=>
    rdata_o[1] != $past(ov_above_i)) else $error("ok bit");
  a_code_write: assert property (wr_en_i && addr_i == 8'h20 |=>
    ovp_threshold_code_o == $past(wdata_i[5:0])) else $error("code");
  a_mv_map: assert property (!$past(srst_i) |->
    ovp_mv_o == mv($past(ovp_threshold_code_o))) else $error("mv");
  a_rst_code: assert property ($fell(srst_i) |-> ovp_mv_o == 16'h6f54 &&
    ovp_threshold_code_o == 6'h3f) else $error("reset code");
  a_ro_zero: assert property (rd_en_i |=> rvalid_o &&
    (rdata_o & $past(ro_m)) == 8'h00) else $error("read-only bit");
  c_ov_read: cover property (rd_en_i && ov_above_i);
  c_turn_on: cover property ($rose(boost_on_o));
  c_low_code: cover property (wr_en_i && addr_i == 8'h20 && !wdata_i[5]);
endmodule : wbcr_regs_props

// *** verif/wbcr_host.sv ***
// host model on the register strobes
`timescale 1ns/1ps
module wbcr_host (
  input  wire logic       clk_sys_i,        // clock
  input  wire logic       rvalid_i,         // read valid
  input  wire logic [7:0] rdata_i,          // read data
  output logic            wr_en_o, rd_en_o, // strobes
  output logic      [7:0] addr_o, wdata_o   // offset, data
);
  initial begin
    {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h00000;
  end
  // one-cycle request, lines flipped on release
  task automatic req(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys_i);
    {wr_en_o, rd_en_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge clk_sys_i);
    {wr_en_o, rd_en_o, addr_o, wdata_o} <= {2'h0, ~a, ~d};
  endtask : req
  // read, bounded wait for valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic to);
    req(1'b0, a, 8'h00);
    to = 1'b1;
    for (int i = 0; i < 4 && to; i++) begin
      #1;
      to = (rvalid_i !== 1'b1);
      d = rdata_i;
      if (to) begin
        @(posedge clk_sys_i);
      end
    end
  endtask : rd
endmodule : wbcr_host

// *** verif/test_wbcr_regs.sv ***
// self-checking bench, boost register bank
`timescale 1ns/1ps
module test_wbcr_regs;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ov_above_i = 1'b0;
  logic        wr_en_i, rd_en_i, rvalid_o, boost_on_o, to;
  logic [7:0]  addr_i, wdata_i, rdata_o, d;
  logic [5:0]  ovp_threshold_code_o;
  logic [15:0] ovp_mv_o;
  int          mismatches = 0;
  int          compares = 0;
  logic [23:0] wt [4] = '{24'h20ff3f, 24'h21fe00, 24'h22c000, 24'h230802};
  logic [21:0] cm [3] = '{{6'h00, 16'h1388}, {6'h27, 16'h4074}, {6'h1b, 16'h2de6}};
  // 4 ns clock
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  wbcr_host host_u (.clk_sys_i(clk_sys_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  wbcr_regs dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .ov_above_i(ov_above_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .boost_on_o(boost_on_o),
    .ovp_threshold_code_o(ovp_threshold_code_o), .ovp_mv_o(ovp_mv_o));
  // compare and count
  task automatic chk(input string n, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // read and compare, a lost answer ends the run
  task automatic rc(input logic [7:0] ad, e);
    host_u.rd(ad, d, to);
    if (to) begin
      mismatches++;
      stop_test();
    end
    chk("rdata", {8'h00, d}, {8'h00, e});
  endtask : rc
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rc(8'h20, 8'h3f);
    chk("mv", ovp_mv_o, 16'h6f54);
    host_u.req(1'b1, 8'h23, 8'h01);
    rc(8'h23, 8'h03);
    chk("on", {15'h0, boost_on_o}, 16'h0001);
    @(posedge clk_sys_i);
    ov_above_i <= 1'b1;
    rc(8'h23, 8'h01);
    @(posedge clk_sys_i);
    ov_above_i <= 1'b0;
    rc(8'h23, 8'h03);
    foreach (cm[i]) begin
      host_u.req(1'b1, 8'h20, {2'h0, cm[i][21:16]});
      rc(8'h20, {2'h0, cm[i][21:16]});
      chk("mv", ovp_mv_o, cm[i][15:0]);
      chk("code", {10'h000, ovp_threshold_code_o}, {10'h000, cm[i][21:16]});
    end
    foreach (wt[i]) begin
      host_u.req(1'b1, wt[i][23:16], wt[i][15:8]);
      rc(wt[i][23:16], wt[i][7:0]);
    end
    chk("on", {15'h0, boost_on_o}, 16'h0000);
    rc(8'h30, 8'h00);
    stop_test();
  end
endmodule : test_wbcr_regs
bind wbcr_regs wbcr_regs_props chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .ov_above_i(ov_above_i), .rvalid_o(rvalid_o),
  .boost_on_o(boost_on_o), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .ovp_threshold_code_o(ovp_threshold_code_o), .ovp_mv_o(ovp_mv_o));
